// ===== verilog/power_mode_control_regs.vh
/*
  constants of the host-side power mode controller: window offsets,
  command codes, mode codes, sequence values and bus timing.
  assumes a 25 MHz host clock and an 8KB device window on a 13-bit address.
*/
`ifndef POWER_MODE_CONTROL_REGS_VH
`define POWER_MODE_CONTROL_REGS_VH

// window offsets
`define OFS_CONTROL        13'h1006
`define OFS_CONFIRM        13'h1076
`define OFS_WAKE           13'h1fff

// control values written in a sequence; confirmation is the complement
`define CTRL_VAL_RESET     16'h0000
`define CTRL_VAL_NORMAL    16'h0001
`define CTRL_VAL_POWERDOWN 16'h0002
`define WAKE_READS         3'h4

// command codes
`define CMD_READ           4'h0
`define CMD_WRITE          4'h1
`define CMD_SET_NORMAL     4'h2
`define CMD_SET_RESET      4'h3
`define CMD_POWER_DOWN     4'h4
`define CMD_WAKE_READS     4'h5
`define CMD_WAKE_BOOT      4'h6
`define CMD_RESET_PULSE    4'h7
`define CMD_RESET_HOLD     4'h8
`define CMD_RESET_RELEASE  4'h9

// device mode as tracked by the host
`define MODE_RESET         2'h0
`define MODE_NORMAL        2'h1
`define MODE_POWERDOWN     2'h2

// timing
`define CLK_PERIOD_NS      40
`define T_STROBE_NS        80
`define T_HOLD_NS          40
`define T_EXT_STROBE_NS    200
`define T_EXT_HOLD_NS      120
`define T_RESET_PULSE_NS   1000
`define NS_TO_CYC(ns)      (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== verilog/bus_cycle.v
/*
  one read or write cycle on the device's standard interface:
  address setup, strobe for a given number of cycles, then hold.
  assumes start is only given while o_idle is high.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_cycle (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_start,
  input  wire        i_write,
  input  wire [12:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire [7:0]  i_strobe_cyc,
  input  wire [7:0]  i_hold_cyc,
  input  wire [15:0] i_data_in,
  output wire        o_ce_n,
  output wire        o_oe_n,
  output wire        o_we_n,
  output wire        o_byte_high_enable_n,
  output wire [12:0] o_addr,
  output wire [15:0] o_data_out,
  output wire        o_data_oe_n,
  output wire [15:0] o_rdata,
  output wire        o_done,
  output wire        o_idle
);

  localparam S_IDLE   = 4'b0001;
  localparam S_SETUP  = 4'b0010;
  localparam S_STROBE = 4'b0100;
  localparam S_HOLD   = 4'b1000;

  reg [3:0]  state_ff;
  reg [7:0]  cnt_ff;
  reg        write_ff;
  reg        ce_n_ff;
  reg        oe_n_ff;
  reg        we_n_ff;
  reg        bhe_n_ff;
  reg [12:0] addr_ff;
  reg [15:0] wdata_ff;
  reg        data_oe_n_ff;
  reg [15:0] rdata_ff;
  reg        done_ff;

  //////////////////////////////////////////////////////////////////////
  // cycle sequencer; idle pins sit at the rails with chip enable negated
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= 8'h00;
      write_ff     <= 1'b0;
      ce_n_ff      <= 1'b1;
      oe_n_ff      <= 1'b1;
      we_n_ff      <= 1'b1;
      bhe_n_ff     <= 1'b1;
      addr_ff      <= 13'h0000;
      wdata_ff     <= 16'h0000;
      data_oe_n_ff <= 1'b0;
      rdata_ff     <= 16'h0000;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (i_start) begin
            write_ff     <= i_write;
            addr_ff      <= i_addr;
            wdata_ff     <= i_write ? i_wdata : 16'h0000;
            data_oe_n_ff <= ~i_write;
            ce_n_ff      <= 1'b0;
            bhe_n_ff     <= 1'b0;
            state_ff     <= S_SETUP;
          end
        end
        S_SETUP: begin
          oe_n_ff  <= write_ff;
          we_n_ff  <= ~write_ff;
          cnt_ff   <= i_strobe_cyc - 8'h01;
          state_ff <= S_STROBE;
        end
        S_STROBE: begin
          if (cnt_ff == 8'h00) begin
            if (!write_ff) begin
              rdata_ff <= i_data_in;
            end
            oe_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            cnt_ff   <= i_hold_cyc - 8'h01;
            state_ff <= S_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        S_HOLD: begin
          if (cnt_ff == 8'h00) begin
            ce_n_ff      <= 1'b1;
            bhe_n_ff     <= 1'b1;
            addr_ff      <= 13'h0000;
            wdata_ff     <= 16'h0000;
            data_oe_n_ff <= 1'b0;
            done_ff      <= 1'b1;
            state_ff     <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  assign o_ce_n               = ce_n_ff;
  assign o_oe_n               = oe_n_ff;
  assign o_we_n               = we_n_ff;
  assign o_byte_high_enable_n = bhe_n_ff;
  assign o_addr               = addr_ff;
  assign o_data_out           = wdata_ff;
  assign o_data_oe_n          = data_oe_n_ff;
  assign o_rdata              = rdata_ff;
  assign o_done               = done_ff;
  assign o_idle               = (state_ff == S_IDLE);

endmodule

`default_nettype wire

// ===== verilog/power_mode_control.v
/*
  host-side controller that steers the flash disk device between reset,
  normal and deep power-down modes through its bus pins and reset input.
  assumes a standard (non-multiplexed) interface, inputs synchronous to i_clk,
  and a device window mapped at offset zero of o_addr.
*/
// Operation
// R1: in reset mode the device drops writes except control and confirmation writes.
// R2: in reset mode every register read of the device returns zero.
// R3: host reads registers only after bringing the device into normal mode.
// R4: standard interface input buffers are off in power-down while chip enable negated.
// R5: multiplexed interface input buffers are off in power-down while chip enable negated.
// R6: power-down entered by control/confirmation writes, host then holds pins at rails.
// R7: holding reset low while in normal mode puts the device into power-down.
// R8: releasing that held reset puts the device into reset mode.
// R9: in power-down writes do nothing and reads return undriven data.
// R10: power-down entry and exit leave all register values unchanged.
// R11: four reads of offset 0x1FFF wake the device; their data is undefined.
// R12: one lengthened boot block read also wakes the device with correct data.
// R13: a booting host wakes the device by pulsing reset and waiting busy negated.
// R14: a valid control then confirmation write moves the device into normal mode.
// R15: asserting reset or power-up boot detection puts the device into reset mode.
// R16: wake read counter restarts on any access other than a 0x1FFF read.
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_control_regs.vh"

module power_mode_control (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_cmd_valid,
  input  wire [3:0]  i_cmd,
  input  wire [12:0] i_cmd_addr,
  input  wire [15:0] i_cmd_wdata,
  output wire        o_cmd_ready,
  output wire        o_cmd_refused,
  output wire        o_rdata_valid,
  output wire [15:0] o_rdata,
  output wire [1:0]  o_mode,
  input  wire        i_busy_n,
  input  wire [15:0] i_data_in,
  output wire        o_ce_n,
  output wire        o_oe_n,
  output wire        o_we_n,
  output wire        o_byte_high_enable_n,
  output wire [12:0] o_addr,
  output wire [15:0] o_data_out,
  output wire        o_data_oe_n,
  output wire        o_reset_in_n
);

  localparam S_IDLE     = 5'b00001;
  localparam S_ISSUE    = 5'b00010;
  localparam S_WAIT     = 5'b00100;
  localparam S_RST_LOW  = 5'b01000;
  localparam S_RST_WAIT = 5'b10000;

  localparam [31:0] STROBE_CYC     = `NS_TO_CYC(`T_STROBE_NS);
  localparam [31:0] HOLD_CYC       = `NS_TO_CYC(`T_HOLD_NS);
  localparam [31:0] EXT_STROBE_CYC = `NS_TO_CYC(`T_EXT_STROBE_NS);
  localparam [31:0] EXT_HOLD_CYC   = `NS_TO_CYC(`T_EXT_HOLD_NS);
  localparam [31:0] RST_PULSE_CYC  = `NS_TO_CYC(`T_RESET_PULSE_NS);

  reg [4:0]  state_ff;
  reg [3:0]  cmd_ff;
  reg [12:0] addr_ff;
  reg [15:0] wdata_ff;
  reg [2:0]  step_ff;
  reg [7:0]  rst_cnt_ff;
  reg [1:0]  mode_ff;
  reg [1:0]  prior_mode_ff;
  reg        reset_n_ff;
  reg        refused_ff;
  reg        rvalid_ff;
  reg [15:0] rdata_ff;
  reg        rst_wait_ff;

  wire        cyc_done;
  wire        cyc_idle;
  wire [15:0] cyc_rdata;

  reg         seq_write;
  reg  [12:0] seq_addr;
  reg  [15:0] seq_wdata;
  reg  [2:0]  seq_len;
  reg  [15:0] ctrl_val;
  reg         accept;

  //////////////////////////////////////////////////////////////////////
  // per-step cycle of the running command
  always @* begin
    ctrl_val  = `CTRL_VAL_RESET;
    seq_write = 1'b0;
    seq_addr  = addr_ff;
    seq_wdata = wdata_ff;
    seq_len   = 3'h1;
    case (cmd_ff)
      `CMD_WRITE: begin
        seq_write = 1'b1;
      end
      `CMD_SET_NORMAL, `CMD_SET_RESET, `CMD_POWER_DOWN: begin
        if (cmd_ff == `CMD_SET_NORMAL) begin
          ctrl_val = `CTRL_VAL_NORMAL;                            // R14
        end else if (cmd_ff == `CMD_POWER_DOWN) begin
          ctrl_val = `CTRL_VAL_POWERDOWN;                         // R6
        end
        seq_write = 1'b1;
        seq_len   = 3'h2;
        seq_addr  = (step_ff == 3'h0) ? `OFS_CONTROL : `OFS_CONFIRM;  // R1
        seq_wdata = (step_ff == 3'h0) ? ctrl_val : ~ctrl_val;
      end
      `CMD_WAKE_READS: begin
        seq_addr = `OFS_WAKE;                                     // R11
        seq_len  = `WAKE_READS;                                   // R16
      end
      default: begin
        seq_len = 3'h1;
      end
    endcase
  end

  // reads refused outside normal mode, plain writes refused in power-down
  always @* begin
    accept = 1'b1;
    if (i_cmd == `CMD_READ && mode_ff != `MODE_NORMAL) begin
      accept = 1'b0;                                              // R3 R2
    end
    if (i_cmd == `CMD_WRITE && mode_ff == `MODE_POWERDOWN) begin
      accept = 1'b0;                                              // R9
    end
    if (i_cmd > `CMD_RESET_RELEASE) begin
      accept = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command sequencer and device mode tracker
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_ff      <= S_IDLE;
      cmd_ff        <= `CMD_READ;
      addr_ff       <= 13'h0000;
      wdata_ff      <= 16'h0000;
      step_ff       <= 3'h0;
      rst_cnt_ff    <= 8'h00;
      mode_ff       <= `MODE_RESET;
      prior_mode_ff <= `MODE_NORMAL;
      reset_n_ff    <= 1'b1;
      refused_ff    <= 1'b0;
      rvalid_ff     <= 1'b0;
      rdata_ff      <= 16'h0000;
      rst_wait_ff   <= 1'b0;
    end else begin
      refused_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (i_cmd_valid) begin
            if (!accept) begin
              refused_ff <= 1'b1;
            end else if (i_cmd == `CMD_RESET_PULSE) begin
              reset_n_ff <= 1'b0;                                 // R13
              rst_cnt_ff <= RST_PULSE_CYC[7:0] - 8'h01;
              state_ff   <= S_RST_LOW;
            end else if (i_cmd == `CMD_RESET_HOLD) begin
              reset_n_ff <= 1'b0;
              if (mode_ff == `MODE_NORMAL) begin
                mode_ff <= `MODE_POWERDOWN;                       // R7
              end else if (mode_ff != `MODE_POWERDOWN) begin
                mode_ff <= `MODE_RESET;                           // R15
              end
            end else if (i_cmd == `CMD_RESET_RELEASE) begin
              reset_n_ff <= 1'b1;
              mode_ff    <= `MODE_RESET;                          // R8
            end else begin
              cmd_ff   <= i_cmd;
              addr_ff  <= i_cmd_addr;
              wdata_ff <= i_cmd_wdata;
              step_ff  <= 3'h0;
              state_ff <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (step_ff + 3'h1 == seq_len) begin
              state_ff <= S_IDLE;
              case (cmd_ff)
                `CMD_READ: begin
                  rdata_ff  <= cyc_rdata;
                  rvalid_ff <= 1'b1;
                end
                `CMD_SET_NORMAL: begin
                  mode_ff <= `MODE_NORMAL;                        // R14
                end
                `CMD_SET_RESET: begin
                  mode_ff <= `MODE_RESET;
                end
                `CMD_POWER_DOWN: begin
                  prior_mode_ff <= mode_ff;                       // R10
                  mode_ff       <= `MODE_POWERDOWN;               // R6
                end
                `CMD_WAKE_READS, `CMD_WAKE_BOOT: begin
                  if (mode_ff == `MODE_POWERDOWN) begin
                    mode_ff <= prior_mode_ff;                     // R11 R12 R10
                  end
                  if (cmd_ff == `CMD_WAKE_BOOT) begin
                    rdata_ff  <= cyc_rdata;                       // R12
                    rvalid_ff <= 1'b1;
                  end
                end
                default: begin
                  mode_ff <= mode_ff;
                end
              endcase
            end else begin
              step_ff  <= step_ff + 3'h1;
              state_ff <= S_ISSUE;
            end
          end
        end
        S_RST_LOW: begin
          if (rst_cnt_ff == 8'h00) begin
            reset_n_ff  <= 1'b1;
            rst_wait_ff <= 1'b1;
            mode_ff     <= `MODE_RESET;                           // R15
            state_ff    <= S_RST_WAIT;
          end else begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
          end
        end
        S_RST_WAIT: begin
          if (i_busy_n) begin
            rst_wait_ff <= 1'b0;                                  // R13
            state_ff    <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bus cycle engine; chip enable stays negated between cycles
  bus_cycle u_bus_cycle (
    .i_clk                (i_clk),
    .i_reset              (i_reset),
    .i_start              (state_ff == S_ISSUE),
    .i_write              (seq_write),
    .i_addr               (seq_addr),
    .i_wdata              (seq_wdata),
    .i_strobe_cyc         ((cmd_ff == `CMD_WAKE_BOOT) ? EXT_STROBE_CYC[7:0] : STROBE_CYC[7:0]),
    .i_hold_cyc           ((cmd_ff == `CMD_WAKE_BOOT) ? EXT_HOLD_CYC[7:0] : HOLD_CYC[7:0]),
    .i_data_in            (i_data_in),
    .o_ce_n               (o_ce_n),
    .o_oe_n               (o_oe_n),
    .o_we_n               (o_we_n),
    .o_byte_high_enable_n (o_byte_high_enable_n),
    .o_addr               (o_addr),
    .o_data_out           (o_data_out),
    .o_data_oe_n          (o_data_oe_n),
    .o_rdata              (cyc_rdata),
    .o_done               (cyc_done),
    .o_idle               (cyc_idle)
  );

  assign o_cmd_ready   = (state_ff == S_IDLE) && cyc_idle && !rst_wait_ff;
  assign o_cmd_refused = refused_ff;
  assign o_rdata_valid = rvalid_ff;
  assign o_rdata       = rdata_ff;
  assign o_mode        = mode_ff;
  assign o_reset_in_n  = reset_n_ff;

endmodule

`default_nettype wire

// ===== sim/power_mode_control_monitor.sv
/* checker of power_mode_control: command answers, strobes, reset pin.
   assumes a bind to the top module; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_control_regs.vh"

module power_mode_control_monitor (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_cmd_valid,
  input wire logic [3:0] i_cmd,
  input wire logic       o_cmd_ready,
  input wire logic       o_cmd_refused,
  input wire logic       o_rdata_valid,
  input wire logic [1:0] o_mode,
  input wire logic       o_ce_n,
  input wire logic       o_oe_n,
  input wire logic       o_we_n,
  input wire logic       o_byte_high_enable_n,
  input wire logic       o_reset_in_n
);
  logic [7:0] low_cnt_ff;
  logic       pulse_ff;

  // low time of the reset pin and kind of the last reset command
  always @(posedge i_clk) begin
    if (i_reset) begin
      low_cnt_ff <= 8'h00;
      pulse_ff   <= 1'b0;
    end else begin
      low_cnt_ff <= o_reset_in_n ? 8'h00 : low_cnt_ff + 8'h01;
      if (o_cmd_ready && i_cmd_valid && (i_cmd == `CMD_RESET_PULSE)) begin
        pulse_ff <= 1'b1;
      end else if (o_cmd_ready && i_cmd_valid && (i_cmd == `CMD_RESET_HOLD)) begin
        pulse_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_take(logic [3:0] c);
    o_cmd_ready && i_cmd_valid && (i_cmd == c);
  endsequence
  sequence s_we_strobe;
    !o_we_n [*2] ##1 o_we_n;
  endsequence

  AST_READ_REFUSED: assert property (
    s_take(`CMD_READ) ##0 (o_mode != `MODE_NORMAL) |=> o_cmd_refused)
    else $error("read outside normal mode not refused");
  AST_READ_ANSWER: assert property (
    s_take(`CMD_READ) ##0 (o_mode == `MODE_NORMAL) |-> ##7 o_rdata_valid)
    else $error("read data not valid seven cycles after take");
  AST_BAD_CODE: assert property (
    o_cmd_ready && i_cmd_valid && (i_cmd > 4'h9) |=> o_cmd_refused ##1 $stable(o_mode))
    else $error("unknown command not refused");
  AST_PD_WRITE: assert property (
    s_take(`CMD_WRITE) ##0 (o_mode == `MODE_POWERDOWN) |=> o_cmd_refused)
    else $error("write in power-down not refused");
  AST_HOLD_PD: assert property (
    s_take(`CMD_RESET_HOLD) ##0 (o_mode == `MODE_NORMAL) |=> !o_reset_in_n ##[0:2] (o_mode == `MODE_POWERDOWN))
    else $error("reset hold in normal mode not power-down");
  AST_RELEASE: assert property (
    s_take(`CMD_RESET_RELEASE) |=> o_reset_in_n ##[0:2] (o_mode == `MODE_RESET))
    else $error("reset release not reset mode");
  AST_PULSE_WIDTH: assert property (
    $rose(o_reset_in_n) && pulse_ff |-> (low_cnt_ff == 8'h19))
    else $error("reset pulse width wrong");
  AST_WRITE_STROBE: assert property (
    $fell(o_we_n) |-> s_we_strobe)
    else $error("write strobe length wrong");
  AST_BHE_WITH_CE: assert property (
    o_byte_high_enable_n == o_ce_n)
    else $error("byte high enable differs from chip enable");
  AST_IDLE_RAILS: assert property (
    o_ce_n |-> (o_oe_n && o_we_n))
    else $error("strobe active while chip enable negated");
endmodule

bind power_mode_control power_mode_control_monitor i_mon (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready),
  .o_cmd_refused(o_cmd_refused),
  .o_rdata_valid(o_rdata_valid),
  .o_mode(o_mode),
  .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n),
  .o_we_n(o_we_n),
  .o_byte_high_enable_n(o_byte_high_enable_n),
  .o_reset_in_n(o_reset_in_n)
);
`default_nettype wire

// ===== sim/flash_disk_model.sv
/* device model: modes, control writes, reads, wake-up and busy.
   assumes the standard bus and reset pin of power_mode_control. */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_control_regs.vh"

module flash_disk_model #(
  parameter int BUSY_NS = 220
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [12:0] i_addr,
  input  wire logic [15:0] i_host_data,
  input  wire logic        i_host_oe_n,
  input  wire logic        i_reset_in_n,
  output var  logic [15:0] o_bus,
  output var  logic        o_busy_n
);
  logic [1:0]  mode = `MODE_RESET;
  logic [15:0] ctrl = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] mem [0:15];
  int          wake_cnt = 0;
  realtime     t_oe = 0.0;

  initial begin
    o_busy_n = 1'b1;
    foreach (mem[k]) mem[k] = 16'h0000;
  end

  ////////////////////////////////////////
  always @(negedge i_reset_in_n) begin
    if (mode == `MODE_NORMAL) mode = `MODE_POWERDOWN;
  end
  always @(posedge i_reset_in_n) begin
    mode = `MODE_RESET;
    o_busy_n = 1'b0;
    #(BUSY_NS) o_busy_n = 1'b1;
  end
  always @(posedge i_we_n) begin
    if (!i_ce_n && mode != `MODE_POWERDOWN) begin
      if (i_addr == `OFS_CONTROL) begin
        ctrl = i_host_data;
      end else if (i_addr == `OFS_CONFIRM && i_host_data == ~ctrl) begin
        if (ctrl == `CTRL_VAL_NORMAL) mode = `MODE_NORMAL;
        if (ctrl == `CTRL_VAL_RESET) mode = `MODE_RESET;
        if (ctrl == `CTRL_VAL_POWERDOWN && mode == `MODE_NORMAL) mode = `MODE_POWERDOWN;
      end else if (mode == `MODE_NORMAL) begin
        mem[i_addr[3:0]] = i_host_data;
      end
    end
  end
  always @(negedge i_oe_n) t_oe = $realtime;
  always @(posedge i_oe_n) begin
    last = o_bus;
    if (!i_ce_n && mode == `MODE_POWERDOWN) begin
      wake_cnt = (i_addr == `OFS_WAKE) ? wake_cnt + 1 : 0;
      if (wake_cnt == 4 || $realtime - t_oe >= `T_EXT_STROBE_NS) begin
        mode = `MODE_NORMAL;
        wake_cnt = 0;
      end
    end
  end
  always @(*) begin
    if (!i_host_oe_n) o_bus = i_host_data;
    else if (!i_ce_n && !i_oe_n && mode == `MODE_NORMAL) o_bus = mem[i_addr[3:0]];
    else if (!i_ce_n && !i_oe_n && mode == `MODE_RESET) o_bus = 16'h0000;
    else o_bus = ~last;
  end
endmodule
`default_nettype wire

// ===== sim/power_mode_control_tb_top.sv
/* testbench of power_mode_control with a device model and a mode reference.
   assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_control_regs.vh"

module power_mode_control_tb_top;
  logic        i_clk;
  logic        i_reset;
  logic        i_cmd_valid;
  logic [3:0]  i_cmd;
  logic [12:0] i_cmd_addr;
  logic [15:0] i_cmd_wdata;
  wire         o_cmd_ready;
  wire         o_cmd_refused;
  wire         o_rdata_valid;
  wire  [15:0] o_rdata;
  wire  [1:0]  o_mode;
  wire         i_busy_n;
  wire  [15:0] i_data_in;
  wire         o_ce_n;
  wire         o_oe_n;
  wire         o_we_n;
  wire         o_byte_high_enable_n;
  wire  [12:0] o_addr;
  wire  [15:0] o_data_out;
  wire         o_data_oe_n;
  wire         o_reset_in_n;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          exp_mode = 0;
  logic [15:0] ref_mem [0:15];

  power_mode_control i_power_mode_control (.i_clk, .i_reset, .i_cmd_valid, .i_cmd, .i_cmd_addr, .i_cmd_wdata,
    .o_cmd_ready, .o_cmd_refused, .o_rdata_valid, .o_rdata, .o_mode, .i_busy_n, .i_data_in, .o_ce_n, .o_oe_n,
    .o_we_n, .o_byte_high_enable_n, .o_addr, .o_data_out, .o_data_oe_n, .o_reset_in_n);
  flash_disk_model dev_model (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr),
    .i_host_data(o_data_out), .i_host_oe_n(o_data_oe_n), .i_reset_in_n(o_reset_in_n), .o_bus(i_data_in),
    .o_busy_n(i_busy_n));

  ////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_cmd(input logic [3:0] c, input logic [12:0] a, input logic [15:0] d);
    int   n;
    logic ref_seen;
    logic rv_seen;
    logic exp_ref;
    logic exp_rv;
    logic [15:0] rd;
    n = 0;
    ref_seen = 1'b0;
    rv_seen = 1'b0;
    rd = 16'h0000;
    exp_ref = (c > 4'h9) || (c == `CMD_READ && exp_mode != 1) || (c == `CMD_WRITE && exp_mode == 2);
    exp_rv = (c == `CMD_READ || c == `CMD_WAKE_BOOT) && !exp_ref;
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    i_cmd_addr <= a;
    i_cmd_wdata <= d;
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
      if (o_cmd_refused === 1'b1) ref_seen = 1'b1;
      if (o_rdata_valid === 1'b1) rv_seen = 1'b1;
      if (o_rdata_valid === 1'b1) rd = o_rdata;
    end while (!(o_cmd_ready === 1'b1 && n >= 3) && n < 2000);
    check("command done", {15'h0000, n < 2000}, 16'h0001);
    check("refused", {15'h0000, ref_seen}, {15'h0000, exp_ref});
    check("read valid", {15'h0000, rv_seen}, {15'h0000, exp_rv});
    if (c == `CMD_READ && !exp_ref) check("read data", rd, ref_mem[a[3:0]]);
    if (!exp_ref) begin
      case (c)
        `CMD_WRITE: if (exp_mode == 1) ref_mem[a[3:0]] = d;
        `CMD_SET_NORMAL, `CMD_WAKE_READS, `CMD_WAKE_BOOT: exp_mode = 1;
        `CMD_POWER_DOWN: exp_mode = 2;
        `CMD_RESET_HOLD: exp_mode = (exp_mode == 0) ? 0 : 2;
        `CMD_SET_RESET, `CMD_RESET_PULSE, `CMD_RESET_RELEASE: exp_mode = 0;
        default: ;
      endcase
    end
    check("host mode", {14'h0000, o_mode}, exp_mode[15:0]);
    check("device mode", {14'h0000, dev_model.mode}, exp_mode[15:0]);
  endtask

  ////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    logic [15:0] d;
    logic [12:0] a;
    i_reset = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = 4'h0;
    i_cmd_addr = 13'h0000;
    i_cmd_wdata = 16'h0000;
    foreach (ref_mem[k]) ref_mem[k] = 16'h0000;
    void'($urandom(79162));
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    do_cmd(`CMD_READ, 13'h0003, 16'h0000);
    do_cmd(`CMD_WRITE, 13'h0003, 16'h1234);
    do_cmd(`CMD_SET_NORMAL, 13'h0000, 16'h0000);
    do_cmd(`CMD_READ, 13'h0003, 16'h0000);
    repeat (8) begin
      a = 13'($urandom % 16);
      d = 16'($urandom);
      do_cmd(`CMD_WRITE, a, d);
      do_cmd(`CMD_READ, a, 16'h0000);
    end
    do_cmd(`CMD_SET_RESET, 13'h0000, 16'h0000);
    do_cmd(`CMD_READ, 13'h0001, 16'h0000);
    do_cmd(`CMD_SET_NORMAL, 13'h0000, 16'h0000);
    do_cmd(`CMD_POWER_DOWN, 13'h0000, 16'h0000);
    do_cmd(`CMD_WRITE, 13'h0001, 16'($urandom));
    do_cmd(`CMD_READ, `OFS_WAKE, 16'h0000);
    do_cmd(`CMD_WAKE_READS, 13'h0000, 16'h0000);
    for (int i = 0; i < 16; i++) do_cmd(`CMD_READ, 13'(i), 16'h0000);
    do_cmd(`CMD_POWER_DOWN, 13'h0000, 16'h0000);
    do_cmd(`CMD_WAKE_BOOT, 13'h0000, 16'h0000);
    do_cmd(`CMD_RESET_HOLD, 13'h0000, 16'h0000);
    do_cmd(`CMD_RESET_RELEASE, 13'h0000, 16'h0000);
    do_cmd(`CMD_SET_NORMAL, 13'h0000, 16'h0000);
    do_cmd(`CMD_RESET_PULSE, 13'h0000, 16'h0000);
    do_cmd(`CMD_SET_NORMAL, 13'h0000, 16'h0000);
    for (int c = 10; c < 16; c++) do_cmd(4'(c), 13'h0000, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
